// ### logic/deadband_delay.sv
`timescale 1ns/1ns
`include "epwm_regs.svh"

module deadband_delay
    import epwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       level_in,
    input  wire logic [7:0] delay_count,
    output logic            level_out
);

    db_state_e  state_q;
    logic [7:0] cnt_q;

    // output is combinational so the only pipeline stage is the pin flop downstream
    always_comb begin
        level_out = level_in & ((delay_count == 8'h00) || (state_q == DB_ACTIVE) ||
                    ((state_q == DB_COUNT) && (cnt_q == delay_count)));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= DB_IDLE;
            cnt_q   <= 8'h00;
        end else if (!level_in) begin
            // falling edge passes at once and aborts a pending delay
            state_q <= DB_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (state_q)
                DB_IDLE: begin
                    if (delay_count == 8'h00) begin
                        state_q <= DB_ACTIVE;
                    end else begin
                        state_q <= DB_COUNT;
                        cnt_q   <= 8'h01;
                    end
                end
                DB_COUNT: begin
                    if (cnt_q >= delay_count) begin
                        state_q <= DB_ACTIVE;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                DB_ACTIVE: begin
                    state_q <= DB_ACTIVE;
                end
                default: begin
                    state_q <= DB_IDLE;
                end
            endcase
        end
    end

endmodule

// ### logic/dir_lead_timer.sv
`timescale 1ns/1ns
`include "epwm_regs.svh"

module dir_lead_timer
    import epwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       period_boundary,
    input  wire logic [1:0] timer_prescale_select,
    output logic            lead_reached
);

    localparam int LEAD00 = (`LEAD_TOSC_PS00 + `CLK_PS - 1) / `CLK_PS;
    localparam int LEAD01 = (`LEAD_TOSC_PS01 + `CLK_PS - 1) / `CLK_PS;
    localparam int LEAD1X = (`LEAD_TOSC_PS1X + `CLK_PS - 1) / `CLK_PS;
    localparam logic [`LEN_W-1:0] LEAD00_C = LEAD00[`LEN_W-1:0];
    localparam logic [`LEN_W-1:0] LEAD01_C = LEAD01[`LEN_W-1:0];
    localparam logic [`LEN_W-1:0] LEAD1X_C = LEAD1X[`LEN_W-1:0];
    localparam logic [`LEN_W-1:0] LEN_MAX  = {`LEN_W{1'b1}};

    logic [`LEN_W-1:0] cnt_q;
    logic [`LEN_W-1:0] last_len_q;
    logic              len_valid_q;
    logic [`LEN_W-1:0] lead;

    always_comb begin
        case (timer_prescale_select)
            2'b00:   lead = LEAD00_C;
            2'b01:   lead = LEAD01_C;
            default: lead = LEAD1X_C;
        endcase
    end

    // the period length is learnt from the previous cycle; a period change
    // therefore shifts the lead point for one cycle only
    always_comb begin
        lead_reached = len_valid_q && (last_len_q > lead) &&
                       ((cnt_q + 1'b1) >= (last_len_q - lead));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q       <= '0;
            last_len_q  <= '0;
            len_valid_q <= 1'b0;
        end else if (period_boundary) begin
            cnt_q       <= '0;
            last_len_q  <= (cnt_q == LEN_MAX) ? LEN_MAX : cnt_q + 1'b1;
            len_valid_q <= 1'b1;
        end else if (cnt_q != LEN_MAX) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule

// ### logic/enhanced_bridge_pwm_steering.sv
// Functional notes
// - four outputs; mode bits 7:6, polarity 1:0
// - software picks active-high or active-low outputs
// - control shadowed, loaded at period boundary
// - deadband loads at duty or period boundary
// - outputs lag standard waveform one cycle
// - single, half, full forward, full reverse
// - single mode: standard waveform on A
// - half-bridge: PWM on A, complement B
// - half-bridge: active edge delayed deadband count
// - delay above duty keeps output inactive
// - deadband never delays active-to-inactive edge
// - full forward: A held, D modulated
// - full reverse: C held, B modulated
// - full-bridge has no deadband delay
// - direction bit change applies next cycle
// - A/C switch early by prescale lead
// - B and D inactive during direction transition
// - latches valid after one cycle, flag rises
// - pins undriven until configured as outputs
// - eight-bit deadband counts instruction cycles
// - PWM outputs override parallel slave port
`timescale 1ns/1ns
`include "epwm_regs.svh"

module enhanced_bridge_pwm_steering
    import epwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] enhanced_pwm_control,
    input  wire logic [7:0] deadband_count_value,
    input  wire logic [3:0] port_direction_bits,
    input  wire logic [1:0] timer_prescale_select,
    input  wire logic       period_boundary,
    input  wire logic       duty_active,
    input  wire logic       duty_boundary,
    input  wire logic       flag_clear,
    output logic            bridge_output_a,
    output logic            bridge_output_a_oe,
    output logic            bridge_output_b,
    output logic            bridge_output_b_oe,
    output logic            bridge_output_c,
    output logic            bridge_output_c_oe,
    output logic            bridge_output_d,
    output logic            bridge_output_d_oe,
    output logic [3:0]      parallel_slave_port_override,
    output logic            period_timer_flag,
    output logic            first_cycle_done
);

    function automatic logic is_full(input logic [1:0] m);
        is_full = (m == MODE_FULL_FWD) || (m == MODE_FULL_REV);
    endfunction

    function automatic logic pwm_on(input logic [7:0] c);
        pwm_on = (c[`CTRL_EN_HI:`CTRL_EN_LO] == `CTRL_PWM_ON);
    endfunction

    // pins taken over from the parallel port in each configuration
    function automatic logic [3:0] owns_of(input logic [1:0] m);
        case (m)
            MODE_SINGLE: owns_of = 4'b0001;
            MODE_HALF:   owns_of = 4'b0011;
            default:     owns_of = 4'b1111;
        endcase
    endfunction

    function automatic logic low_active(input logic [7:0] c, input int idx);
        if ((idx == `PIN_A) || (idx == `PIN_C)) begin
            low_active = c[`CTRL_POL_AC_BIT];
        end else begin
            low_active = c[`CTRL_POL_BD_BIT];
        end
    endfunction

    logic [7:0] ctrl_act_q;
    logic [7:0] del_act_q;
    logic       del_loaded_q;
    logic       trans_q;
    logic       enabled_seen_q;
    logic       first_done_q;
    logic       flag_q;
    logic [3:0] pin_q;
    logic [3:0] oe_q;
    logic [3:0] owns_q;

    logic [1:0] act_mode;
    logic [1:0] new_mode;
    logic       enabled;
    logic       lead_reached;
    logic [1:0] db_in;
    logic [1:0] db_out;
    logic [3:0] active_d;
    logic [3:0] owns_d;
    logic [3:0] pol_low;
    logic       db_load;
    logic [7:0] del_use;
    logic       dir_change;

    assign act_mode = ctrl_act_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign new_mode = enhanced_pwm_control[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign enabled  = pwm_on(ctrl_act_q);

    // shadow copy goes live only at the timer reset so no output glitches mid-cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_act_q <= `CTRL_RESET;
        end else if (period_boundary) begin
            ctrl_act_q <= enhanced_pwm_control;
        end
    end

    // deadband loads at the first duty boundary of each cycle, and at a period boundary only if no duty boundary came since the last one; the
    // value being loaded already times the edge that starts on that boundary
    assign db_load = (period_boundary || duty_boundary) && !del_loaded_q;
    assign del_use = db_load ? deadband_count_value : del_act_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            del_act_q <= `DEL_RESET;
        end else if (db_load) begin
            del_act_q <= deadband_count_value;
        end
    end

    // a period boundary re-arms the load for the next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            del_loaded_q <= 1'b0;
        end else if (period_boundary) begin
            del_loaded_q <= 1'b0;
        end else if (duty_boundary) begin
            del_loaded_q <= 1'b1;
        end
    end

    dir_lead_timer u_lead (
        .clk                   (clk),
        .rst                   (rst),
        .period_boundary       (period_boundary),
        .timer_prescale_select (timer_prescale_select),
        .lead_reached          (lead_reached)
    );

    // a live full-bridge run whose shadow asks for the other direction
    assign dir_change = enabled && is_full(act_mode) && is_full(new_mode) &&
                        pwm_on(enhanced_pwm_control) &&
                        (new_mode[1] != act_mode[1]);

    // transition interval: from the lead point to the boundary that
    // makes the new direction the active one
    always_ff @(posedge clk) begin
        if (rst) begin
            trans_q <= 1'b0;
        end else if (period_boundary) begin
            trans_q <= 1'b0;
        end else if (dir_change && lead_reached) begin
            trans_q <= 1'b1;
        end
    end

    assign db_in[0] = duty_active;
    assign db_in[1] = ~duty_active;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_db
            deadband_delay u_db (
                .clk         (clk),
                .rst         (rst),
                .level_in    (db_in[g] & enabled & (act_mode == MODE_HALF)),
                .delay_count (del_use),
                .level_out   (db_out[g])
            );
        end
    endgenerate

    always_comb begin
        owns_d = 4'h0;
        if (enabled) begin
            owns_d = owns_of(act_mode);
        end
    end

    always_comb begin
        active_d = 4'h0;
        if (enabled) begin
            case (act_mode)
                MODE_SINGLE: begin
                    active_d[`PIN_A] = duty_active;
                end
                MODE_HALF: begin
                    // each leg passes through its own deadband counter
                    active_d[`PIN_A] = db_out[0];
                    active_d[`PIN_B] = db_out[1];
                end
                MODE_FULL_FWD, MODE_FULL_REV: begin
                    // no deadband: only one leg is modulated at a time
                    if (trans_q) begin
                        // modulated legs stay off while the held legs swap
                        active_d[`PIN_A] = (new_mode == MODE_FULL_FWD);
                        active_d[`PIN_C] = (new_mode == MODE_FULL_REV);
                        active_d[`PIN_B] = 1'b0;
                        active_d[`PIN_D] = 1'b0;
                    end else if (act_mode == MODE_FULL_FWD) begin
                        active_d[`PIN_A] = 1'b1;
                        active_d[`PIN_D] = duty_active;
                    end else begin
                        active_d[`PIN_C] = 1'b1;
                        active_d[`PIN_B] = duty_active;
                    end
                end
                default: begin
                    active_d = 4'h0;
                end
            endcase
        end
    end

    // a and c share one polarity bit, b and d the other
    generate
        for (g = 0; g < 4; g++) begin : g_pol
            assign pol_low[g] = low_active(ctrl_act_q, g);
        end
    endgenerate

    // the pin flop is the single stage behind the timer reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_q <= 4'h0;
        end else begin
            pin_q <= active_d ^ pol_low;
        end
    end

    // port takeover follows the live configuration, not the direction bits
    always_ff @(posedge clk) begin
        if (rst) begin
            owns_q <= 4'h0;
        end else begin
            owns_q <= owns_d;
        end
    end

    // a pin set as input stays undriven whatever the stage is doing
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_q <= 4'h0;
        end else begin
            oe_q <= owns_d & ~port_direction_bits;
        end
    end

    // completion of one full cycle after enabling: the first enabled boundary
    // only starts the cycle, the second one ends it
    always_ff @(posedge clk) begin
        if (rst) begin
            enabled_seen_q <= 1'b0;
        end else if (!pwm_on(enhanced_pwm_control)) begin
            enabled_seen_q <= 1'b0;
        end else if (period_boundary) begin
            enabled_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            first_done_q <= 1'b0;
        end else if (!pwm_on(enhanced_pwm_control)) begin
            first_done_q <= 1'b0;
        end else if (period_boundary) begin
            first_done_q <= enabled_seen_q | first_done_q;
        end
    end

    // sticky flag: a boundary in the same cycle as a clear wins
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (period_boundary) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // every pin, enable and status output leaves straight from a flop
    assign bridge_output_a              = pin_q[`PIN_A];
    assign bridge_output_b              = pin_q[`PIN_B];
    assign bridge_output_c              = pin_q[`PIN_C];
    assign bridge_output_d              = pin_q[`PIN_D];
    assign bridge_output_a_oe           = oe_q[`PIN_A];
    assign bridge_output_b_oe           = oe_q[`PIN_B];
    assign bridge_output_c_oe           = oe_q[`PIN_C];
    assign bridge_output_d_oe           = oe_q[`PIN_D];
    assign parallel_slave_port_override = owns_q;
    assign period_timer_flag            = flag_q;
    assign first_cycle_done             = first_done_q;

endmodule

// ### logic/epwm_pkg.sv
package epwm_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'b00,
        MODE_FULL_FWD = 2'b01,
        MODE_HALF     = 2'b10,
        MODE_FULL_REV = 2'b11
    } out_mode_e;

    typedef enum logic [2:0] {
        DB_IDLE   = 3'b001,
        DB_COUNT  = 3'b010,
        DB_ACTIVE = 3'b100
    } db_state_e;

endpackage

// ### logic/epwm_regs.svh
`ifndef EPWM_REGS_SVH
`define EPWM_REGS_SVH

// control byte layout
`define CTRL_MODE_HI      7
`define CTRL_MODE_LO      6
`define CTRL_DIR_BIT      7
`define CTRL_EN_HI        3
`define CTRL_EN_LO        2
`define CTRL_POL_AC_BIT   1
`define CTRL_POL_BD_BIT   0
`define CTRL_PWM_ON       2'b11

// reset values
`define CTRL_RESET        8'h00
`define DEL_RESET         8'h00

// pin index within the four bridge pins
`define PIN_A             0
`define PIN_B             1
`define PIN_C             2
`define PIN_D             3

// timing: oscillator period and instruction clock period in ps
`define TOSC_PS           12500
`define CLK_PS            50000
`define LEAD_TOSC_PS00    (1 * `TOSC_PS)
`define LEAD_TOSC_PS01    (4 * `TOSC_PS)
`define LEAD_TOSC_PS1X    (16 * `TOSC_PS)

// cycles between period boundaries fit in this many bits (256 counts x 16 prescale)
`define LEN_W             13

`endif

// ### verification/bridge_switches.sv
`timescale 1ns/1ns
// gate drivers with pull-downs: an undriven pin holds its switch off
module bridge_switches (
    input wire logic [3:0] pin,
    input wire logic [3:0] oe,
    output logic     [3:0] pad
);
    assign pad = oe & pin;
endmodule

// ### verification/enhanced_bridge_pwm_steering_tb.sv
`timescale 1ns/1ns
module enhanced_bridge_pwm_steering_tb
    import epwm_pkg::*;
;
    localparam int P = 12;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] del = 8'h00;
    logic [3:0] dirb = 4'hf;
    logic [1:0] ps = 2'b00;
    logic       pb = 1'b0;
    logic       da = 1'b0;
    logic       db = 1'b0;
    logic       fc = 1'b0;
    logic       run = 1'b0;
    wire  [3:0] pin;
    wire  [3:0] oe;
    wire  [3:0] parallel_slave_port;
    wire  [3:0] pad;
    wire        flag;
    wire        fcd;
    integer     seed = 32'hc487;
    int         cnt = 0;
    int         w = 0;
    int         lim = P + 1;
    int         ra = 0;
    int         rb = 0;
    int         n_fail = 0;
    int         checked = 0;
    logic [7:0] m_act = 8'h00;
    logic [7:0] m_del = 8'h00;
    logic       ml = 1'b0;
    logic       mv = 1'b0;
    logic [3:0] mo = 4'h0;
    logic [3:0] eo = 4'h0;
    logic [3:0] ex = 4'h0;
    out_mode_e  ml_list [4] = '{MODE_SINGLE, MODE_HALF, MODE_FULL_FWD, MODE_FULL_REV};

    enhanced_bridge_pwm_steering DUT (
        .clk(clk), .rst(rst), .enhanced_pwm_control(ctrl), .deadband_count_value(del),
        .port_direction_bits(dirb), .timer_prescale_select(ps), .period_boundary(pb),
        .duty_active(da), .duty_boundary(db), .flag_clear(fc),
        .bridge_output_a(pin[0]), .bridge_output_a_oe(oe[0]),
        .bridge_output_b(pin[1]), .bridge_output_b_oe(oe[1]),
        .bridge_output_c(pin[2]), .bridge_output_c_oe(oe[2]),
        .bridge_output_d(pin[3]), .bridge_output_d_oe(oe[3]),
        .parallel_slave_port_override(parallel_slave_port), .period_timer_flag(flag), .first_cycle_done(fcd)
    );
    bridge_switches u_sw (.pin(pin), .oe(oe), .pad(pad));

    always #25 clk = ~clk;

    // period timer stand-in: fixed period, random duty each period
    always @(posedge clk) begin
        #1;
        cnt = cnt == P - 1 ? 0 : cnt + 1;
        if (cnt == 0) w = {$random(seed)} % lim;
        pb = run && cnt == 0;
        da = run && cnt < w;
        db = run && cnt == w;
    end

    task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // reference: pins after an edge follow the inputs sampled at that edge
    always @(posedge clk) begin
        if (mv) begin
            chk4("pins", ex & mo, pin & mo);
            chk4("oe", eo, oe);
            chk4("psp", mo, parallel_slave_port);
        end
        if (rst) begin
            m_act = 8'h00;
            m_del = 8'h00;
            ml = 1'b0;
            mv = 1'b0;
        end else begin
            mo = m_act[3:2] != 2'b11 ? 4'h0 : m_act[6] ? 4'hf : m_act[7] ? 4'h3 : 4'h1;
            // deadband run lengths count only while the half-bridge is live
            ra = da && mo == 4'h3 ? ra + 1 : 0;
            rb = !da && mo == 4'h3 ? rb + 1 : 0;
            eo = mo & ~dirb;
            if ((db || pb) && !ml) m_del = del;
            case (m_act[7:6])
                MODE_SINGLE: ex = {3'b000, da};
                MODE_HALF: ex = {2'b00, rb > m_del, ra > m_del};
                MODE_FULL_FWD: ex = {da, 3'b001};
                default: ex = {2'b01, da, 1'b0};
            endcase
            ex = ex ^ {m_act[0], m_act[1], m_act[0], m_act[1]};
            // a pending full-bridge direction change is measured by flip instead
            mv = ctrl[7:6] == m_act[7:6] || !(ctrl[6] && m_act[6]);
            if (db) ml = 1'b1;
            if (pb) begin
                ml = 1'b0;
                m_act = ctrl;
            end
        end
    end

    task automatic nxt(input int n);
        repeat (n) begin
            @(posedge clk);
            while (pb !== 1'b1) @(posedge clk);
        end
        @(posedge clk);
        #1;
    endtask

    task automatic flip(input logic [7:0] nc, input logic [3:0] lead);
        logic [3:0] n;
        n = 4'h0;
        @(posedge clk);
        while (pb !== 1'b1) @(posedge clk);
        #1;
        ctrl = nc;
        repeat (P + 1) begin
            @(posedge clk);
            if (pin[0] == !nc[7] && pin[2] == nc[7]) begin
                n++;
                chk4("bd", 4'h0, pin & 4'ha);
            end
        end
        chk4("lead", lead, n);
    endtask

    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(4000 * 50);
        n_fail++;
        stop_test;
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        chk4("pad", 4'h0, pad);
        chk4("flag", 4'h0, {3'b000, flag});
        run = 1'b1;
        ctrl = 8'h8c;
        nxt(1);
        chk4("flag", 4'h1, {3'b000, flag});
        chk4("first", 4'h0, {3'b000, fcd});
        nxt(1);
        chk4("first", 4'h1, {3'b000, fcd});
        dirb = 4'h0;
        $display("test startup done");
        foreach (ml_list[i]) begin
            for (int p = 0; p < 4; p++) begin
                ctrl = {ml_list[i], 4'h0, p[1:0]};
                nxt(1);
                ctrl = {ml_list[i], 4'h3, p[1:0]};
                del = p == 3 ? 8'h14 : 8'({$random(seed)} % 6);
                nxt(1);
                fc = 1'b1;
                @(posedge clk);
                #1;
                fc = 1'b0;
                chk4("clear", 4'h0, {3'b000, flag});
                nxt(2);
            end
        end
        $display("test modes done");
        lim = P - 2;
        ctrl = 8'h40;
        nxt(1);
        for (int s = 0; s < 4; s++) begin
            ps = s[1:0];
            ctrl = 8'h4c;
            nxt(2);
            flip(8'hcc, s[1] ? 4'h4 : 4'h1);
            nxt(1);
            flip(8'h4c, s[1] ? 4'h4 : 4'h1);
        end
        $display("test direction done");
        stop_test;
    end
endmodule

// ### verification/epwm_chk.sv
`timescale 1ns/1ns
module epwm_chk
    import epwm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] enhanced_pwm_control,
    input wire logic [3:0] port_direction_bits,
    input wire logic       period_boundary,
    input wire logic       duty_active,
    input wire logic       flag_clear,
    input wire logic       bridge_output_a,
    input wire logic       bridge_output_a_oe,
    input wire logic       bridge_output_b,
    input wire logic       bridge_output_b_oe,
    input wire logic       bridge_output_c,
    input wire logic       bridge_output_c_oe,
    input wire logic       bridge_output_d,
    input wire logic       bridge_output_d_oe,
    input wire logic [3:0] parallel_slave_port_override,
    input wire logic       period_timer_flag
);
    logic [7:0] act_q;
    logic [7:0] act1_q;
    logic       ok1_q;
    logic       ok2_q;
    logic [3:0] own;
    logic [3:0] pv;
    logic [3:0] pin;
    logic [3:0] oe;
    logic       st;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst) begin
            act_q <= 8'h00;
            act1_q <= 8'h00;
            ok1_q <= 1'b0;
            ok2_q <= 1'b0;
        end else begin
            if (period_boundary) act_q <= enhanced_pwm_control;
            act1_q <= act_q;
            ok1_q <= enhanced_pwm_control == act_q;
            ok2_q <= ok1_q;
        end
    end
    assign pin = {bridge_output_d, bridge_output_c, bridge_output_b, bridge_output_a};
    assign oe = {bridge_output_d_oe, bridge_output_c_oe, bridge_output_b_oe, bridge_output_a_oe};
    assign own = act1_q[3:2] != 2'b11 ? 4'h0 : act1_q[6] ? 4'hf : act1_q[7] ? 4'h3 : 4'h1;
    assign pv = {act1_q[0], act1_q[1], act1_q[0], act1_q[1]};
    // settled windows only: a direction change in flight is judged by the bench
    assign st = ok1_q && ok2_q && act1_q == act_q && own != 4'h0;
    sequence set_s;
        period_boundary ##1 period_timer_flag;
    endsequence
    reset_idle_a: assert property ($fell(rst) |-> pin == 4'h0 && oe == 4'h0)
        else $error("outputs not idle after reset");
    flag_set_a: assert property (period_boundary |-> set_s)
        else $error("flag not set by boundary");
    flag_clr_a: assert property (flag_clear && !period_boundary |=> !period_timer_flag)
        else $error("flag not cleared");
    oe_map_a: assert property (st |-> oe == (own & ~$past(port_direction_bits)))
        else $error("output enables wrong");
    psp_own_a: assert property (st |-> parallel_slave_port_override == own)
        else $error("port override wrong");
    single_out_a: assert property (st && act1_q[7:6] == MODE_SINGLE
        |-> bridge_output_a == ($past(duty_active) ^ act1_q[1]))
        else $error("single output wrong");
    fwd_out_a: assert property (st && act1_q[7:6] == MODE_FULL_FWD
        |-> pin == ({$past(duty_active), 3'b001} ^ pv))
        else $error("forward outputs wrong");
    rev_out_a: assert property (st && act1_q[7:6] == MODE_FULL_REV
        |-> pin == ({2'b01, $past(duty_active), 1'b0} ^ pv))
        else $error("reverse outputs wrong");
    half_off_a: assert property (st && act1_q[7:6] == MODE_HALF |-> ($past(duty_active)
        ? bridge_output_b == act1_q[0] : bridge_output_a == act1_q[1]))
        else $error("half bridge off edge wrong");
endmodule

bind enhanced_bridge_pwm_steering epwm_chk u_chk (
    .clk, .rst, .enhanced_pwm_control, .port_direction_bits, .period_boundary,
    .duty_active, .flag_clear, .bridge_output_a, .bridge_output_a_oe, .bridge_output_b,
    .bridge_output_b_oe, .bridge_output_c, .bridge_output_c_oe, .bridge_output_d,
    .bridge_output_d_oe, .parallel_slave_port_override, .period_timer_flag
);
